// [ebimx_pkg.sv]
// shared types and constants of the external bus pin multiplexer
package ebimx_pkg;
  localparam int ADDR_W = 26;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int CS_W = 8;
  localparam int SD_ADDR_W = 13;
  localparam int BF_ADDR_W = 25;
  // pin positions of shared functions
  localparam int CS_BFC = 0;
  localparam int CS_SDRAM = 1;
  localparam int CS_NAND = 3;
  localparam int CS_CARD = 4;
  localparam int CS_CARD_CE1 = 5;
  localparam int CS_CARD_CE2 = 6;
  localparam int PIN_CARD_RNW = 25;
  localparam int PIN_SD_BANK = 16;
  localparam int SD_PRECHARGE_BIT = 10;
  // idle and reset levels of the pins
  localparam logic [ADDR_W-1:0] ADDR_RST = 26'h0000000;
  localparam logic [CS_W-1:0] CS_IDLE = 8'hff;
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic [DATA_W-1:0] DOE_RST = 32'h00000000;
  localparam logic [DATA_W-1:0] DOUT_RST = 32'h00000000;

  typedef enum logic [1:0] {OWN_IDLE, OWN_SMC, OWN_SDRAM, OWN_BFC} ebimx_owner_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [CS_W-1:0] cs_n;
    logic [1:0] wr_n;
    logic rd_n;
    logic lb_n;
    logic ub_n;
    logic bus16;
    logic nand_cs_n;
    logic card_cs_n;
    logic [1:0] card_ce_n;
    logic card_io_acc;
    logic card_io_read_n;
    logic card_read_not_write;
    logic [HALF_W-1:0] wdata;
    logic wdata_oe;
  } ebimx_smc_s;

  typedef struct packed {
    logic [SD_ADDR_W-1:0] addr;
    logic [1:0] bank;
    logic cs_n;
    logic [3:0] dqm_n;
    logic [DATA_W-1:0] wdata;
    logic wdata_oe;
  } ebimx_sdram_s;

  typedef struct packed {
    logic [BF_ADDR_W-1:0] addr;
    logic cs_n;
    logic avd_req;
    logic [HALF_W-1:0] wdata;
    logic wdata_oe;
  } ebimx_bfc_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [CS_W-1:0] cs_n;
    logic upper_n;
    logic low_wr_n;
    logic rd_n;
    logic sdram_precharge_addr_bit;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] doe;
  } ebimx_pins_s;
endpackage

// [ebimx_sync.sv]
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module ebimx_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    meta <= din;
    dout <= meta;
  end
endmodule

// [ebimx_bf_link.sv]
// burst flash link domain: address-valid strobe and ready crossing
`timescale 1ns/1ps
module ebimx_bf_link (
  // system side
  input wire logic clk,
  input wire logic rst_n,
  input wire logic avd_req,
  output logic ready,
  // link side
  input wire logic link_clk,
  input wire logic ready_pin,
  output logic avd_n
);
  logic req_tgl, next_req_tgl;
  logic lrst_meta, lrst_n;
  logic t_meta, t_sync, t_last;
  logic next_avd_n;
  logic r_meta, r_link, c_meta;

  // event toggles in the system domain
  always_comb begin
    next_req_tgl = rst_n ? (req_tgl ^ avd_req) : 1'b0;
  end

  always_ff @(posedge clk) begin
    req_tgl <= next_req_tgl;
  end

  // reset and toggle brought into the link domain
  always_ff @(posedge link_clk) begin
    lrst_meta <= rst_n;
    lrst_n <= lrst_meta;
    t_meta <= req_tgl;
    t_sync <= t_meta;
  end

  // one link cycle low per requested burst start address
  always_comb begin
    next_avd_n = ~(t_sync ^ t_last);
    if (!lrst_n) begin
      next_avd_n = 1'b1;
    end
  end

  always_ff @(posedge link_clk) begin
    t_last <= lrst_n ? t_sync : 1'b0;
    avd_n <= next_avd_n;
  end

  // ready pin synchronised on the link clock, then handed to the system clock
  always_ff @(posedge link_clk) begin
    r_meta <= ready_pin;
    r_link <= r_meta;
  end

  always_ff @(posedge clk) begin
    c_meta <= r_link;
    ready <= c_meta;
  end

  a_avd_strobe: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (t_sync != t_last) |=> !avd_n)
    else $error("address valid not driven for a burst start");
  a_avd_single: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (t_sync == t_last) |=> avd_n)
    else $error("address valid driven without a request");
endmodule

// [ebimx_top.sv]
// pin multiplexer sharing the external bus among three memory controllers
// Operation
// - pin meaning follows whichever controller currently owns the bus
// - sdram address 9..0 on pins 11..2, bits 12..11 on pins 14..13
// - sdram address bit 10 on its own dedicated pin
// - 16-bit static: pin A0 lower select, strobe 1 upper select, low
// - upper select pin shared with strobe 1 and card io read
// - burst flash chip select low on first chip select pin, if configured
// - sdram chip select low on second chip select pin, if configured
// - nand chip select low on fourth chip select pin
// - card mode: card select on fifth pin, card enables on sixth, seventh
// - card mode: read-not-write on address pin 25
// - burst flash address valid low marks burst start address cycle
// - no access: address and output controls held stable
`timescale 1ns/1ps
module ebimx_top (
  // system
  input wire logic CLK,
  input wire logic RST_N,
  // link clock of the burst flash
  input wire logic BF_LINK_CLK,
  // configuration
  input wire logic CS0_BURST_FLASH,
  input wire logic CS1_SDRAM,
  input wire logic NAND_EN,
  input wire logic CARD_EN,
  // controller requests and grants
  input wire logic SMC_REQ,
  input wire logic SDRAM_REQ,
  input wire logic BFC_REQ,
  output logic SMC_GNT,
  output logic SDRAM_GNT,
  output logic BFC_GNT,
  // controller signals
  input wire ebimx_pkg::ebimx_smc_s STATIC_MEM_CTRL,
  input wire ebimx_pkg::ebimx_sdram_s SDRAM,
  input wire ebimx_pkg::ebimx_bfc_s BFC,
  output logic [ebimx_pkg::DATA_W-1:0] RDATA,
  output logic BURST_FLASH_READY_SYNC,
  // external pins
  output logic [ebimx_pkg::ADDR_W-1:0] ADDR,
  output logic [ebimx_pkg::CS_W-1:0] CHIP_SELECT_N,
  output logic UPPER_BYTE_SELECT_N,
  output logic LOW_WRITE_STROBE_N,
  output logic READ_STROBE_N,
  output logic SDRAM_PRECHARGE_ADDR_BIT,
  output logic [ebimx_pkg::DATA_W-1:0] DATA_OUT,
  output logic [ebimx_pkg::DATA_W-1:0] DATA_OE,
  input wire logic [ebimx_pkg::DATA_W-1:0] DATA_IN,
  input wire logic BURST_FLASH_READY,
  output logic BURST_FLASH_ADDR_VALID_N
);
  import ebimx_pkg::*;

  ebimx_owner_e own, next_own;
  ebimx_pins_s pins, next_pins;
  logic bfc_avd_req;

  // bus ownership: a held request keeps the bus, so bursts are not broken
  always_comb begin
    next_own = own;
    case (own)
      OWN_IDLE: begin
        if (SDRAM_REQ) begin
          next_own = OWN_SDRAM;
        end else if (BFC_REQ) begin
          next_own = OWN_BFC;
        end else if (SMC_REQ) begin
          next_own = OWN_SMC;
        end
      end
      OWN_SMC: begin
        if (!SMC_REQ) begin
          next_own = OWN_IDLE;
        end
      end
      OWN_SDRAM: begin
        if (!SDRAM_REQ) begin
          next_own = OWN_IDLE;
        end
      end
      OWN_BFC: begin
        if (!BFC_REQ) begin
          next_own = OWN_IDLE;
        end
      end
      default: begin
        next_own = OWN_IDLE;
      end
    endcase
    if (!RST_N) begin
      next_own = OWN_IDLE;
    end
  end

  always_ff @(posedge CLK) begin
    own <= next_own;
  end

  assign SMC_GNT = (own == OWN_SMC);
  assign SDRAM_GNT = (own == OWN_SDRAM);
  assign BFC_GNT = (own == OWN_BFC);

  // static controller chip selects with the shared functions folded in
  function automatic logic [CS_W-1:0] smc_cs(input ebimx_smc_s s, input logic cs0_bf,
                                             input logic cs1_sd, input logic nand_en,
                                             input logic card_en);
    logic [CS_W-1:0] c;
    c = s.cs_n;
    if (cs0_bf) begin
      c[CS_BFC] = 1'b1;
    end
    if (cs1_sd) begin
      c[CS_SDRAM] = 1'b1;
    end
    if (nand_en) begin
      c[CS_NAND] = s.nand_cs_n;
    end
    if (card_en) begin
      c[CS_CARD] = s.card_cs_n;
      c[CS_CARD_CE1] = s.card_ce_n[0];
      c[CS_CARD_CE2] = s.card_ce_n[1];
    end
    return c;
  endfunction

  // pin values for the current owner; idle keeps the address as it was
  always_comb begin
    next_pins = pins;
    next_pins.cs_n = CS_IDLE;
    next_pins.upper_n = STROBE_IDLE;
    next_pins.low_wr_n = STROBE_IDLE;
    next_pins.rd_n = STROBE_IDLE;
    next_pins.doe = DOE_RST;
    case (own)
      OWN_SMC: begin
        next_pins.addr = STATIC_MEM_CTRL.addr;
        next_pins.cs_n = smc_cs(STATIC_MEM_CTRL, CS0_BURST_FLASH, CS1_SDRAM, NAND_EN, CARD_EN);
        next_pins.low_wr_n = STATIC_MEM_CTRL.wr_n[0];
        next_pins.rd_n = STATIC_MEM_CTRL.rd_n;
        if (STATIC_MEM_CTRL.bus16) begin
          next_pins.addr[0] = STATIC_MEM_CTRL.lb_n;
          next_pins.upper_n = STATIC_MEM_CTRL.ub_n;
        end else begin
          next_pins.upper_n = STATIC_MEM_CTRL.wr_n[1];
        end
        if (CARD_EN) begin
          next_pins.addr[PIN_CARD_RNW] = STATIC_MEM_CTRL.card_read_not_write;
          if (STATIC_MEM_CTRL.card_io_acc) begin
            next_pins.upper_n = STATIC_MEM_CTRL.card_io_read_n;
          end
        end
        next_pins.dout = {{HALF_W{1'b0}}, STATIC_MEM_CTRL.wdata};
        next_pins.doe = {{HALF_W{1'b0}}, {HALF_W{STATIC_MEM_CTRL.wdata_oe}}};
      end
      OWN_SDRAM: begin
        next_pins.addr[11:2] = SDRAM.addr[9:0];
        next_pins.addr[14:13] = SDRAM.addr[12:11];
        next_pins.addr[PIN_SD_BANK+1:PIN_SD_BANK] = SDRAM.bank;
        next_pins.addr[0] = SDRAM.dqm_n[0];
        next_pins.addr[1] = SDRAM.dqm_n[2];
        next_pins.upper_n = SDRAM.dqm_n[1];
        next_pins.sdram_precharge_addr_bit = SDRAM.addr[SD_PRECHARGE_BIT];
        if (CS1_SDRAM) begin
          next_pins.cs_n[CS_SDRAM] = SDRAM.cs_n;
        end
        next_pins.dout = SDRAM.wdata;
        next_pins.doe = {DATA_W{SDRAM.wdata_oe}};
      end
      OWN_BFC: begin
        next_pins.addr[ADDR_W-1:1] = BFC.addr;
        if (CS0_BURST_FLASH) begin
          next_pins.cs_n[CS_BFC] = BFC.cs_n;
        end
        next_pins.dout = {{HALF_W{1'b0}}, BFC.wdata};
        next_pins.doe = {{HALF_W{1'b0}}, {HALF_W{BFC.wdata_oe}}};
      end
      default: begin
        next_pins.addr = pins.addr;
      end
    endcase
    if (!RST_N) begin
      next_pins.addr = ADDR_RST;
      next_pins.sdram_precharge_addr_bit = 1'b0;
      next_pins.dout = DOUT_RST;
    end
  end

  always_ff @(posedge CLK) begin
    pins <= next_pins;
  end

  assign ADDR = pins.addr;
  assign CHIP_SELECT_N = pins.cs_n;
  assign UPPER_BYTE_SELECT_N = pins.upper_n;
  assign LOW_WRITE_STROBE_N = pins.low_wr_n;
  assign READ_STROBE_N = pins.rd_n;
  assign SDRAM_PRECHARGE_ADDR_BIT = pins.sdram_precharge_addr_bit;
  assign DATA_OUT = pins.dout;
  assign DATA_OE = pins.doe;

  // read data from the pins
  ebimx_sync #(.W(DATA_W)) u_rdata_sync (
    .clk(CLK),
    .din(DATA_IN),
    .dout(RDATA)
  );

  // address valid only while the burst flash owns the bus
  assign bfc_avd_req = BFC.avd_req && (own == OWN_BFC);

  ebimx_bf_link u_bf_link (
    .clk(CLK),
    .rst_n(RST_N),
    .avd_req(bfc_avd_req),
    .ready(BURST_FLASH_READY_SYNC),
    .link_clk(BF_LINK_CLK),
    .ready_pin(BURST_FLASH_READY),
    .avd_n(BURST_FLASH_ADDR_VALID_N)
  );

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_owner_single: assert property ($onehot0({SMC_GNT, SDRAM_GNT, BFC_GNT}))
    else $error("more than one controller owns the bus");
  a_sdram_addr_route: assert property (own == OWN_SDRAM |=>
    ADDR[11:2] == $past(SDRAM.addr[9:0]) && ADDR[14:13] == $past(SDRAM.addr[12:11]))
    else $error("sdram address not on the expected pins");
  a_sdram_precharge: assert property (own == OWN_SDRAM |=>
    SDRAM_PRECHARGE_ADDR_BIT == $past(SDRAM.addr[10]))
    else $error("sdram bit 10 not on its own pin");
  a_smc_byte_sel: assert property (own == OWN_SMC && STATIC_MEM_CTRL.bus16 && !CARD_EN |=>
    ADDR[0] == $past(STATIC_MEM_CTRL.lb_n) && UPPER_BYTE_SELECT_N == $past(STATIC_MEM_CTRL.ub_n))
    else $error("byte selects wrong in 16-bit static mode");
  a_card_io_read: assert property (own == OWN_SMC && CARD_EN && STATIC_MEM_CTRL.card_io_acc |=>
    UPPER_BYTE_SELECT_N == $past(STATIC_MEM_CTRL.card_io_read_n))
    else $error("card io read not on the upper select pin");
  a_bfc_cs0: assert property (own == OWN_BFC && CS0_BURST_FLASH |=>
    CHIP_SELECT_N[0] == $past(BFC.cs_n))
    else $error("burst flash select not on first chip select");
  a_cs0_exclusive: assert property (own == OWN_SMC && CS0_BURST_FLASH |=>
    CHIP_SELECT_N[0])
    else $error("static controller drove a burst flash chip select");
  a_sdram_cs1: assert property (own == OWN_SDRAM && CS1_SDRAM |=>
    CHIP_SELECT_N[1] == $past(SDRAM.cs_n))
    else $error("sdram select not on second chip select");
  a_nand_cs3: assert property (own == OWN_SMC && NAND_EN |=>
    CHIP_SELECT_N[3] == $past(STATIC_MEM_CTRL.nand_cs_n))
    else $error("nand select not on fourth chip select");
  a_card_cs: assert property (own == OWN_SMC && CARD_EN |=>
    CHIP_SELECT_N[6:4] == $past({STATIC_MEM_CTRL.card_ce_n, STATIC_MEM_CTRL.card_cs_n}))
    else $error("card selects misplaced");
  a_card_rnw: assert property (own == OWN_SMC && CARD_EN |=>
    ADDR[25] == $past(STATIC_MEM_CTRL.card_read_not_write))
    else $error("card read-not-write not on address pin 25");
  a_idle_stable: assert property (own == OWN_IDLE |=>
    $stable(ADDR) && CHIP_SELECT_N == CS_IDLE && READ_STROBE_N && LOW_WRITE_STROBE_N)
    else $error("pins moved while no access is running");
  a_upper_data_oe: assert property (own != OWN_SDRAM |=> DATA_OE[31:16] == 16'h0000)
    else $error("upper data pins driven outside sdram access");
  a_sdram_bank: assert property (own == OWN_SDRAM |=> ADDR[17:16] == $past(SDRAM.bank))
    else $error("sdram bank not on its pins");
  a_sdram_dqm: assert property (own == OWN_SDRAM |=>
    ADDR[0] == $past(SDRAM.dqm_n[0]) && ADDR[1] == $past(SDRAM.dqm_n[2]))
    else $error("sdram byte masks not on the low address pins");
  a_sdram_upper: assert property (own == OWN_SDRAM |=>
    UPPER_BYTE_SELECT_N == $past(SDRAM.dqm_n[1]))
    else $error("sdram mask 1 not on the upper select pin");
  a_sdram_data: assert property (own == OWN_SDRAM |=> DATA_OUT == $past(SDRAM.wdata))
    else $error("sdram write data not on the data pins");
  a_sdram_cs_only: assert property (own == OWN_SDRAM |=>
    CHIP_SELECT_N[0] && CHIP_SELECT_N[7:2] == 6'h3f)
    else $error("foreign chip select active during sdram access");
  a_bfc_addr_route: assert property (own == OWN_BFC |=> ADDR[25:1] == $past(BFC.addr))
    else $error("burst flash address not on pins 25..1");
  a_bfc_cs_only: assert property (own == OWN_BFC |=> CHIP_SELECT_N[7:1] == 7'h7f)
    else $error("foreign chip select active during burst flash access");
  a_bfc_strobes: assert property (own == OWN_BFC |=>
    UPPER_BYTE_SELECT_N && READ_STROBE_N && LOW_WRITE_STROBE_N)
    else $error("static strobes active during burst flash access");
  a_smc_addr_route: assert property (own == OWN_SMC && !STATIC_MEM_CTRL.bus16 && !CARD_EN |=>
    ADDR == $past(STATIC_MEM_CTRL.addr))
    else $error("static address not on the address pins");
  a_smc_upper_wr: assert property (own == OWN_SMC && !STATIC_MEM_CTRL.bus16 && !CARD_EN |=>
    UPPER_BYTE_SELECT_N == $past(STATIC_MEM_CTRL.wr_n[1]))
    else $error("write strobe 1 not on the upper select pin");
  a_cs1_exclusive: assert property (own == OWN_SMC && CS1_SDRAM |=> CHIP_SELECT_N[1])
    else $error("static controller drove the sdram chip select");
  a_idle_data_oe: assert property (own == OWN_IDLE |=> DATA_OE == 32'h00000000)
    else $error("data pins driven while no access is running");

  c_sdram_access: cover property (own == OWN_IDLE && SDRAM_REQ ##1 own == OWN_SDRAM);
  c_bfc_burst: cover property (own == OWN_BFC && BFC.avd_req ##[1:3] own == OWN_BFC);
  c_card_access: cover property (own == OWN_SMC && CARD_EN && STATIC_MEM_CTRL.card_io_acc);
  c_handover: cover property (own == OWN_SMC ##1 own == OWN_IDLE ##1 own == OWN_BFC);
endmodule

// [ebimx_flash_model.sv]
// burst flash device model at the far side of the link
`timescale 1ns/1ps
module ebimx_flash_model #(
  parameter int LATENCY = 200
) (
  input wire logic link_clk,
  input wire logic avd_n,
  input wire logic cs_n,
  input wire logic rd_n,
  output logic ready,
  output logic [31:0] data
);
  int count;
  initial begin
    count = 0;
    ready = 1'b0;
    data = 32'h00000000;
  end
  // a burst start drops ready, which rises again after the access latency
  always @(posedge link_clk) begin
    if (!avd_n && !cs_n) begin
      count <= LATENCY;
      ready <= 1'b0;
    end else if (count > 1) begin
      count <= count - 1;
    end else if (count == 1) begin
      count <= 0;
      ready <= 1'b1;
    end else if (cs_n) begin
      ready <= 1'b0;
    end
    // an unselected data bus never holds its last value
    if (!cs_n && !rd_n) begin
      data <= 32'h5a5ac3c3;
    end else begin
      data <= ~data;
    end
  end
endmodule

// [test_external_bus_pin_multiplexer.sv]
// self-checking testbench of the external bus pin multiplexer
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_external_bus_pin_multiplexer;
  import ebimx_pkg::*;
  logic CLK, RST_N, BF_LINK_CLK;
  logic CS0_BURST_FLASH, CS1_SDRAM, NAND_EN, CARD_EN;
  logic SMC_REQ, SDRAM_REQ, BFC_REQ;
  logic [2:0] gnt;
  ebimx_smc_s static_mem_ctrl;
  ebimx_sdram_s sdr;
  ebimx_bfc_s bfc;
  logic [DATA_W-1:0] rdata, dout, doe, din;
  logic rdy_sync, rdy_pin, avd_n, upper_n, wr0_n, rd_n, sdram_precharge_addr_bit;
  logic [ADDR_W-1:0] addr;
  logic [CS_W-1:0] cs_n;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int avd_seen = 0;

  ebimx_top DUT (.CLK(CLK), .RST_N(RST_N), .BF_LINK_CLK(BF_LINK_CLK),
    .CS0_BURST_FLASH(CS0_BURST_FLASH), .CS1_SDRAM(CS1_SDRAM), .NAND_EN(NAND_EN),
    .CARD_EN(CARD_EN), .SMC_REQ(SMC_REQ), .SDRAM_REQ(SDRAM_REQ), .BFC_REQ(BFC_REQ),
    .SMC_GNT(gnt[0]), .SDRAM_GNT(gnt[1]), .BFC_GNT(gnt[2]), .STATIC_MEM_CTRL(static_mem_ctrl), .SDRAM(sdr),
    .BFC(bfc), .RDATA(rdata), .BURST_FLASH_READY_SYNC(rdy_sync), .ADDR(addr),
    .CHIP_SELECT_N(cs_n), .UPPER_BYTE_SELECT_N(upper_n), .LOW_WRITE_STROBE_N(wr0_n),
    .READ_STROBE_N(rd_n), .SDRAM_PRECHARGE_ADDR_BIT(sdram_precharge_addr_bit), .DATA_OUT(dout),
    .DATA_OE(doe), .DATA_IN(din), .BURST_FLASH_READY(rdy_pin),
    .BURST_FLASH_ADDR_VALID_N(avd_n));

  ebimx_flash_model #(.LATENCY(200)) flash (.link_clk(BF_LINK_CLK), .avd_n(avd_n),
    .cs_n(cs_n[CS_BFC]), .rd_n(rd_n), .ready(rdy_pin), .data(din));

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  initial begin
    BF_LINK_CLK = 1'b0;
    #1.7;
    forever #3 BF_LINK_CLK = ~BF_LINK_CLK;
  end
  always @(negedge avd_n) avd_seen++;

  task automatic step(input int n);
    repeat (n) @(negedge CLK);
  endtask

  task automatic wait_gnt(input int b);
    int n;
    n = 0;
    while (gnt[b] !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    step(1);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic test_reset();
    `CHK(cs_n, CS_IDLE)
    `CHK(addr, ADDR_RST)
    `CHK(doe, DOE_RST)
    `CHK(avd_n, 1'b1)
    $display("test reset done");
  endtask

  task automatic test_sdram();
    sdr.addr = 13'h15a5;
    sdr.bank = 2'b01;
    sdr.cs_n = 1'b0;
    sdr.wdata = 32'hdeadbeef;
    sdr.wdata_oe = 1'b1;
    SDRAM_REQ = 1'b1;
    SMC_REQ = 1'b1;
    wait_gnt(1);
    `CHK(gnt, 3'b010)
    `CHK(addr[11:2], 10'h1a5)
    `CHK(addr[14:13], 2'b10)
    `CHK(sdram_precharge_addr_bit, 1'b1)
    `CHK(cs_n[CS_SDRAM], 1'b0)
    `CHK(doe, 32'hffffffff)
    `CHK(dout, 32'hdeadbeef)
    SDRAM_REQ = 1'b0;
    SMC_REQ = 1'b0;
    step(3);
    `CHK(cs_n, CS_IDLE)
    `CHK(doe, 32'h00000000)
    `CHK(addr[14:2], 13'h11a5)
    `CHK({upper_n, wr0_n, rd_n}, 3'b111)
    $display("test sdram done");
  endtask

  task automatic test_static_card();
    CARD_EN = 1'b1;
    NAND_EN = 1'b1;
    static_mem_ctrl.addr = 26'h1234567;
    static_mem_ctrl.bus16 = 1'b1;
    static_mem_ctrl.lb_n = 1'b0;
    static_mem_ctrl.ub_n = 1'b0;
    static_mem_ctrl.nand_cs_n = 1'b0;
    static_mem_ctrl.card_cs_n = 1'b0;
    static_mem_ctrl.card_ce_n = 2'b10;
    static_mem_ctrl.card_read_not_write = 1'b1;
    static_mem_ctrl.wdata_oe = 1'b1;
    SMC_REQ = 1'b1;
    wait_gnt(0);
    `CHK(addr[0], 1'b0)
    `CHK(upper_n, 1'b0)
    `CHK(addr[PIN_CARD_RNW], 1'b1)
    `CHK(addr[24:1], 24'h91a2b3)
    `CHK(cs_n, 8'hc7)
    `CHK(doe, 32'h0000ffff)
    `CHK(dout, 32'h00003c3c)
    static_mem_ctrl.card_io_acc = 1'b1;
    static_mem_ctrl.card_io_read_n = 1'b1;
    static_mem_ctrl.cs_n[0] = 1'b0;
    static_mem_ctrl.rd_n = 1'b0;
    step(4);
    `CHK(upper_n, 1'b1)
    `CHK(rd_n, 1'b0)
    `CHK(rdata, 32'h5a5ac3c3)
    static_mem_ctrl.cs_n[0] = 1'b1;
    static_mem_ctrl.rd_n = 1'b1;
    SMC_REQ = 1'b0;
    CARD_EN = 1'b0;
    NAND_EN = 1'b0;
    step(3);
    $display("test static card done");
  endtask

  task automatic test_burst_flash();
    int n;
    CS0_BURST_FLASH = 1'b1;
    bfc.addr = 25'h0abcdef;
    bfc.cs_n = 1'b0;
    BFC_REQ = 1'b1;
    wait_gnt(2);
    `CHK(addr[25:1], 25'h0abcdef)
    `CHK(cs_n[CS_BFC], 1'b0)
    bfc.avd_req = 1'b1;
    step(1);
    bfc.avd_req = 1'b0;
    step(3);
    `CHK(avd_seen, 1)
    `CHK(rdy_sync, 1'b0)
    n = 0;
    while (rdy_sync !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    `CHK(rdy_sync, 1'b1)
    BFC_REQ = 1'b0;
    step(3);
    `CHK(cs_n[CS_BFC], 1'b1)
    $display("test burst flash done");
  endtask

  initial begin
    RST_N = 1'b0;
    CS0_BURST_FLASH = 1'b0;
    CS1_SDRAM = 1'b1;
    NAND_EN = 1'b0;
    CARD_EN = 1'b0;
    SMC_REQ = 1'b0;
    SDRAM_REQ = 1'b0;
    BFC_REQ = 1'b0;
    static_mem_ctrl = '1;
    static_mem_ctrl.wdata = 16'h3c3c;
    static_mem_ctrl.wdata_oe = 1'b0;
    static_mem_ctrl.card_io_acc = 1'b0;
    sdr = '1;
    bfc = '1;
    bfc.avd_req = 1'b0;
    repeat (12) @(posedge CLK);
    @(negedge CLK);
    test_reset();
    RST_N = 1'b1;
    step(2);
    test_sdram();
    test_static_card();
    test_burst_flash();
    tally_and_finish();
  end
endmodule
